// [rtl/cld_pkg.sv]
package cld_pkg;
  // ==========================================
  // register map
  localparam logic [6:0] A_CTRL   = 7'h00;
  localparam logic [6:0] A_GAIN   = 7'h01;
  localparam logic [6:0] A_LEN_LO = 7'h02;
  localparam logic [6:0] A_LEN_HI = 7'h03;
  localparam logic [6:0] A_THRESH = 7'h04;
  localparam logic [6:0] A_SDELAY = 7'h05;
  localparam logic [6:0] A_STATUS = 7'h06;
  localparam logic [6:0] A_COEF   = 7'h40;
  // ==========================================
  // control fields
  localparam int C_MODE = 0;
  localparam int C_X4   = 2;
  localparam int C_P16  = 3;
  localparam int C_SAT  = 4;
  localparam int C_BYPB = 7;
  localparam int C_LPOE = 8;
  localparam int C_FS   = 9;
  localparam int C_W    = 11;
  localparam logic [C_W-1:0] CTRL_RST = 11'h000;
  // ==========================================
  // status fields
  localparam int S_OVF  = 10;
  localparam int S_THR  = 11;
  localparam int S_STOP = 12;
  // ==========================================
  // sizes
  localparam int NUNIT = 4;
  localparam int NROW  = 8;
  localparam int NCOL  = 8;
  localparam int ULEN  = 1024;
  localparam logic [9:0] AMAX_FULL = 10'h3ff;
  localparam logic [9:0] AMAX_HALF = 10'h1ff;
  localparam int SD_LEN = 16;
  localparam logic [15:0] POS_MAX = 16'h7fff;
  localparam logic [15:0] NEG_MAX = 16'h8000;
  // ==========================================
  // modes
  typedef enum logic [1:0] {
    LM_SYNC  = 2'b00,
    LM_PROG  = 2'b01,
    LM_LSCAN = 2'b11,
    LM_FRAME = 2'b10
  } cld_lmode_t;
  typedef enum logic [1:0] {
    SAT_NONE = 2'b00,
    SAT_DISP = 2'b01,
    SAT_SYM  = 2'b10,
    SAT_RSV  = 2'b11
  } cld_sat_t;
endpackage : cld_pkg

// [rtl/cld_top.sv]
`timescale 1ns/1ps
// Behaviour
// RULE_01 - 32-bit signed accumulation of weighted pixels
// RULE_02 - upper sixteen gain bits output, with sign
// RULE_03 - display option: negatives zero, overflow max
// RULE_04 - symmetric option clamps both overflow directions
// RULE_05 - warning flag on gain stage overflow
// RULE_06 - compare gain output with 16-bit threshold
// RULE_07 - sixteen 8x8 multipliers reused twice or four times
// RULE_08 - 4x4 array acts as 4x8 or 8x8
// RULE_09 - 16-bit pixels halve effective multipliers
// RULE_10 - four 1024 lines, else 512-pixel lines
// RULE_11 - pin inserts or skips first delay
// RULE_12 - pixel port input at reset, output by bit
// RULE_13 - host bypasses extra delay in lower field
// RULE_14 - control bit 7 bypasses port group delay
// RULE_15 - sync mode length counts inactive sync clocks
// RULE_16 - sync active: no write, counter reset
// RULE_17 - counter at maximum stops writes for line
// RULE_18 - programmed 10-bit length, value one less
// RULE_19 - host keeps clock until delayed sync active
// RULE_20 - frame mode: falling edge starts, wrap at length
// RULE_21 - frame host writes while delayed sync low
// RULE_22 - line scan wraps at line end, no pause
// RULE_23 - threshold flag high when pixel exceeds threshold
// RULE_24 - overflow output high on gain overflow
// RULE_25 - delayed copy of sync on output
module cld_top
  import cld_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // pixel stream
  input  wire logic [15:0] pix_i,
  input  wire logic        line_sync_i,
  input  wire logic        bypass_i,
  output logic      [15:0] pix_o,
  output logic             threshold_flag_o,
  output logic             gain_overflow_o,
  output logic             delayed_sync_o,
  // line pixel port
  input  wire logic [7:0]  line_pixel_port_i,
  output logic      [7:0]  line_pixel_port_o,
  output logic             line_pixel_port_oe_o,
  // register port
  input  wire logic [6:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rdata_o
);

  // ==========================================
  // registers
  logic [C_W-1:0] ctrl_q;
  logic [3:0]     gain_q;
  logic [9:0]     len_q;
  logic [15:0]    thr_q;
  logic [3:0]     sdly_q;
  logic [7:0]     coef_q [NROW*NCOL];
  logic [15:0]    rdata_q;

  cld_lmode_t mode;
  cld_sat_t   sat;
  wire x4    = ctrl_q[C_X4];
  wire p16   = ctrl_q[C_P16];
  wire bypb  = ctrl_q[C_BYPB];
  wire lpoe  = ctrl_q[C_LPOE];
  wire [1:0] fs = ctrl_q[C_FS+:2];
  assign mode = cld_lmode_t'(ctrl_q[C_MODE+:2]);
  assign sat  = cld_sat_t'(ctrl_q[C_SAT+:2]);

  wire w_ctrl = wr_i && addr_i == A_CTRL;
  wire w_coef = wr_i && addr_i[6];

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_q <= CTRL_RST; // [RULE_12]
      gain_q <= 4'h0;
      len_q  <= 10'h000;
      thr_q  <= 16'h0000;
      sdly_q <= 4'h0;
    end else if (wr_i) begin
      if (addr_i == A_CTRL) begin
        ctrl_q <= wdata_i[C_W-1:0];
      end else if (addr_i == A_GAIN) begin
        gain_q <= wdata_i[3:0];
      end else if (addr_i == A_LEN_LO) begin
        len_q[7:0] <= wdata_i[7:0]; // [RULE_18]
      end else if (addr_i == A_LEN_HI) begin
        len_q[9:8] <= wdata_i[1:0]; // [RULE_18]
      end else if (addr_i == A_THRESH) begin
        thr_q <= wdata_i; // [RULE_06]
      end else if (addr_i == A_SDELAY) begin
        sdly_q <= wdata_i[3:0];
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < NROW*NCOL; i++) coef_q[i] <= 8'h00;
    end else if (w_coef) begin
      coef_q[addr_i[5:0]] <= wdata_i[7:0];
    end
  end

  // ==========================================
  // pixel phase divider
  logic [1:0] ph_q;
  wire [1:0] ph_last = x4 ? 2'd3 : 2'd1;
  wire       pen     = ph_q >= ph_last; // [RULE_07]

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) ph_q <= 2'd0;
    else         ph_q <= pen ? 2'd0 : ph_q + 2'd1;
  end

  // ==========================================
  // line address control
  logic [9:0] addr_q;
  logic       stop_q;
  logic       run_q;
  logic       sprev_q;
  wire        half  = x4 | p16; // [RULE_10]
  wire [9:0]  amax  = half ? AMAX_HALF : AMAX_FULL; // [RULE_10]
  wire [9:0]  plen  = len_q > amax ? amax : len_q;
  wire [9:0]  lim   = mode == LM_SYNC ? amax : plen; // [RULE_15]
  wire        fall  = sprev_q && !line_sync_i; // [RULE_20]
  wire        wrap  = mode[1]; // [RULE_22]
  logic       wen;

  always_comb begin
    case (mode)
      LM_SYNC, LM_PROG: wen = !line_sync_i && !stop_q; // [RULE_16] [RULE_17]
      LM_FRAME:         wen = !line_sync_i && (run_q || fall); // [RULE_20]
      default:          wen = !line_sync_i; // [RULE_22]
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      addr_q  <= 10'h000;
      stop_q  <= 1'b0;
      run_q   <= 1'b0;
      sprev_q <= 1'b0;
    end else if (pen) begin
      sprev_q <= line_sync_i;
      run_q   <= !line_sync_i && (run_q || fall);
      if (line_sync_i) begin
        addr_q <= 10'h000; // [RULE_16]
        stop_q <= 1'b0;
      end else if (wen) begin
        if (addr_q == lim) begin
          if (wrap) addr_q <= 10'h000; // [RULE_20] [RULE_22]
          else      stop_q <= 1'b1; // [RULE_17] [RULE_18]
        end else begin
          addr_q <= addr_q + 10'd1; // [RULE_15]
        end
      end
    end
  end

  // ==========================================
  // line stores, 4 units of 1024 bytes
  logic [7:0]  mem_q [NUNIT][ULEN];
  logic [7:0]  lo [NUNIT];
  logic [7:0]  hi [NUNIT];
  logic [15:0] uo [NUNIT];
  logic [15:0] ui [NUNIT];
  wire  [15:0] pin  = p16 ? pix_i : {8'h00, pix_i[7:0]};
  wire  [15:0] srcb = lpoe ? uo[1] : {8'h00, line_pixel_port_i};

  always_comb begin
    for (int u = 0; u < NUNIT; u++) begin
      lo[u] = half ? mem_q[u][{1'b0, addr_q[8:0]}] : mem_q[u][addr_q];
      hi[u] = mem_q[u][{1'b1, addr_q[8:0]}];
      uo[u] = !half ? {8'h00, lo[u]} : (p16 ? {hi[u], lo[u]} : {8'h00, hi[u]});
    end
    ui[0] = pin;
    ui[1] = bypass_i ? pin : uo[0]; // [RULE_11]
    ui[2] = srcb;
    ui[3] = bypb ? srcb : uo[2]; // [RULE_14]
  end

  // old contents read above, new written at the same address
  // cleared so that unwritten taps read as zero
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int u = 0; u < NUNIT; u++)
        for (int j = 0; j < ULEN; j++) mem_q[u][j] <= 8'h00;
    end else if (pen && wen) begin
      for (int u = 0; u < NUNIT; u++) begin
        if (half) begin
          mem_q[u][{1'b0, addr_q[8:0]}] <= ui[u][7:0];
          mem_q[u][{1'b1, addr_q[8:0]}] <= p16 ? ui[u][15:8] : lo[u];
        end else begin
          mem_q[u][addr_q] <= ui[u][7:0]; // [RULE_16]
        end
      end
    end
  end

  assign line_pixel_port_o    = uo[3][7:0];
  assign line_pixel_port_oe_o = lpoe; // [RULE_12]

  // ==========================================
  // window taps
  logic [15:0] row [NROW];
  logic [15:0] hw_q [NROW][NCOL];

  always_comb begin
    row[0] = pin;
    for (int k = 1; k < NROW; k++) row[k] = 16'h0000;
    if (half && !p16) begin
      for (int u = 0; u < NUNIT; u++) begin
        row[2*u+1] = {8'h00, lo[u]};
        if (u < NUNIT-1) row[2*u+2] = {8'h00, hi[u]};
      end
    end else begin
      for (int k = 1; k < NUNIT; k++) row[k] = uo[k-1];
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int r = 0; r < NROW; r++)
        for (int c = 0; c < NCOL; c++) hw_q[r][c] <= 16'h0000;
    end else if (pen) begin
      for (int r = 0; r < NROW; r++) begin
        hw_q[r][0] <= row[r];
        for (int c = 1; c < NCOL; c++) hw_q[r][c] <= hw_q[r][c-1];
      end
    end
  end

  // ==========================================
  // multiplier array, 4 deep by 4 wide
  function automatic logic [15:0] mul8(input logic [8:0] a, input logic [7:0] k);
    logic signed [16:0] p;
    p = $signed(a) * $signed(k);
    return p[15:0];
  endfunction : mul8

  wire ch   = (x4 && p16) ? ph_q[1] : (p16 ? 1'b0 : ph_q[0]); // [RULE_08]
  wire rh   = x4 && !p16 && ph_q[1]; // [RULE_08]
  wire bsel = p16 && ph_q[0]; // [RULE_09]
  logic [31:0] psum;
  logic [31:0] acc_q;
  wire  [31:0] acc_sum = (ph_q == 2'd0 ? 32'h0 : acc_q) + psum; // [RULE_01]

  always_comb begin
    logic [2:0]  ri;
    logic [2:0]  ci;
    logic [15:0] px;
    logic [8:0]  a;
    logic [15:0] m;
    ri = 3'd0;
    ci = 3'd0;
    px = 16'h0000;
    a  = 9'h000;
    m  = 16'h0000;
    psum = 32'h0;
    for (int r = 0; r < 4; r++) begin
      for (int c = 0; c < 4; c++) begin
        ri = {rh, 2'(r)};
        ci = {ch, 2'(c)};
        px = hw_q[ri][ci];
        a  = bsel ? {px[15], px[15:8]} : {1'b0, px[7:0]}; // [RULE_09]
        m  = mul8(a, coef_q[{ri, ci}]); // [RULE_07]
        if (bsel) psum = psum + {{8{m[15]}}, m, 8'h00};
        else      psum = psum + {{16{m[15]}}, m}; // [RULE_01]
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) acc_q <= 32'h0;
    else         acc_q <= acc_sum;
  end

  // ==========================================
  // gain, saturation, threshold
  wire [4:0]  sh   = 5'd12 - {1'b0, fs, 2'b00};
  wire [19:0] fld  = 20'(acc_sum >> sh);
  wire signed [24:0] gp = $signed(fld) * $signed({1'b0, gain_q});
  wire        gneg = gp[23];
  wire        govf = !(&gp[23:19]) && (|gp[23:19]); // [RULE_05]
  wire [15:0] mid  = gp[19:4]; // [RULE_02]
  logic [15:0] sat_out;

  always_comb begin
    case (sat)
      SAT_DISP: sat_out = gneg ? 16'h0000 : (govf ? POS_MAX : mid); // [RULE_03]
      SAT_SYM:  sat_out = govf ? (gneg ? NEG_MAX : POS_MAX) : mid; // [RULE_04]
      default:  sat_out = mid; // [RULE_02]
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pix_o            <= 16'h0000;
      gain_overflow_o  <= 1'b0;
      threshold_flag_o <= 1'b0;
    end else if (pen) begin
      pix_o            <= sat_out; // [RULE_02]
      gain_overflow_o  <= govf; // [RULE_24] [RULE_05]
      threshold_flag_o <= $signed(sat_out) > $signed(thr_q); // [RULE_06] [RULE_23]
    end
  end

  // ==========================================
  // delayed sync
  logic [SD_LEN-1:0] sd_q;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) sd_q <= '1;
    else if (pen) sd_q <= {sd_q[SD_LEN-2:0], line_sync_i};
  end

  assign delayed_sync_o = sd_q[sdly_q]; // [RULE_25]

  // ==========================================
  // register read
  wire [15:0] status = {3'b000, stop_q, threshold_flag_o, gain_overflow_o, addr_q};
  wire [15:0] rsel =
    addr_i[6]           ? {8'h00, coef_q[addr_i[5:0]]} :
    addr_i == A_CTRL    ? {5'h00, ctrl_q} :
    addr_i == A_GAIN    ? {12'h000, gain_q} :
    addr_i == A_LEN_LO  ? {8'h00, len_q[7:0]} :
    addr_i == A_LEN_HI  ? {14'h0000, len_q[9:8]} :
    addr_i == A_THRESH  ? thr_q :
    addr_i == A_SDELAY  ? {12'h000, sdly_q} :
    addr_i == A_STATUS  ? status : 16'h0000;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i)   rdata_q <= 16'h0000;
    else if (rd_i) rdata_q <= rsel;
    else           rdata_q <= 16'h0000;
  end

  assign rdata_o = rdata_q;

  // ==========================================
  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  sequence s_pen_x4;
    (pen && x4) ##1 x4[*3];
  endsequence
  sequence s_pen_x2;
    (pen && !x4) ##1 (!x4)[*2];
  endsequence

  a_rate_quad: assert property (s_pen_x4 |=> // [RULE_07]
    pen && !$past(pen) && !$past(pen, 2) && !$past(pen, 3))
    else $error("pixel enable not every 4 clocks");
  a_rate_double: assert property (s_pen_x2 |-> pen && !$past(pen)) // [RULE_08]
    else $error("pixel enable not every 2 clocks");
  a_sync_reset: assert property ((pen && line_sync_i) |=> addr_q == 10'h000 && !stop_q) // [RULE_16]
    else $error("address not reset by sync");
  a_no_wrap: assert property ((pen && !line_sync_i && mode == LM_SYNC && addr_q == amax && !w_ctrl) // [RULE_17]
    |=> addr_q == $past(addr_q) && stop_q)
    else $error("line store wrapped in sync mode");
  a_frame_wrap: assert property ((pen && wen && wrap && addr_q == lim) |=> addr_q == 10'h000) // [RULE_20]
    else $error("frame pointer did not restart");
  a_port_dir: assert property ($rose(line_pixel_port_oe_o) |-> $past(w_ctrl && wdata_i[C_LPOE])) // [RULE_12]
    else $error("pixel port driven without control bit");
  a_disp_sign: assert property ((pen && sat == SAT_DISP) |=> !pix_o[15]) // [RULE_03]
    else $error("display mode output negative");
  a_sym_clamp: assert property ((pen && sat == SAT_SYM && govf) |=> // [RULE_04]
    pix_o == ($past(gneg) ? NEG_MAX : POS_MAX))
    else $error("symmetric clamp wrong");
  a_ovf_flag: assert property (pen |=> gain_overflow_o == $past(govf)) // [RULE_24]
    else $error("overflow output wrong");
  a_ovf_hold: assert property (!pen |=> $stable(gain_overflow_o)) // [RULE_24]
    else $error("overflow output changed between pixels");
  a_thr_flag: assert property (pen |=> threshold_flag_o == ($signed($past(sat_out)) > $signed($past(thr_q)))) // [RULE_23]
    else $error("threshold flag wrong");

endmodule : cld_top

// [testbench/cld_src_model.sv]
`timescale 1ns/1ps
// ==========================================
// video source and neighbour port model
module cld_src_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // bench requests
  input  wire logic        sync_req_i,
  input  wire logic        field_i,
  input  wire logic [15:0] pix_req_i,
  // device side
  input  wire logic        port_oe_i,
  output logic      [15:0] pix_o,
  output logic             line_sync_o,
  output logic             bypass_o,
  output logic      [7:0]  port_o
);
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pix_o       <= 16'h0000;
      line_sync_o <= 1'b1;
      bypass_o    <= 1'b0;
      port_o      <= 8'h00;
    end else begin
      pix_o       <= pix_req_i;
      line_sync_o <= sync_req_i;
      bypass_o    <= field_i;
      port_o      <= port_oe_i ? ~port_o : pix_req_i[7:0];
    end
  end
endmodule : cld_src_model

// [testbench/cld_top_tb.sv]
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; $display("Error %s exp %h got %h", n, e, g); end end
module cld_top_tb;
  import cld_pkg::*;
  // ==========================================
  // signals
  logic        clk_i, nrst_i, wr, rd, sync_req, field, oe, flag, ovf, dsync;
  logic        m_sync, m_byp;
  logic [6:0]  addr;
  logic [7:0]  m_port, d_port, port_in;
  logic [15:0] wdata, rdata, pix_req, m_pix, pix;
  int          fails, cmp_count, cycles;
  // coef, gain, sat, thresh, pix_o, ovf, flag
  localparam logic [55:0] GT [9] = '{56'h7f_1_0_3f40_3f40_0_0, 56'h7f_1_0_3f3f_3f40_0_1,
    56'h7f_f_0_0000_b4c7_1_0, 56'h7f_f_1_0000_7fff_1_1, 56'h7f_f_2_7ffe_7fff_1_1,
    56'h81_1_2_0000_c0bf_0_0, 56'h81_1_1_0000_0000_0_0, 56'h81_f_2_8000_8000_1_0,
    56'h81_f_0_0000_4b38_1_1};
  // ==========================================
  // clock, model and device
  always #12.5 clk_i = ~clk_i;
  assign port_in = oe ? d_port : m_port;
  cld_src_model u_src (.clk_i(clk_i), .nrst_i(nrst_i), .sync_req_i(sync_req), .field_i(field),
    .pix_req_i(pix_req), .port_oe_i(oe), .pix_o(m_pix), .line_sync_o(m_sync), .bypass_o(m_byp),
    .port_o(m_port));
  cld_top u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .pix_i(m_pix), .line_sync_i(m_sync),
    .bypass_i(m_byp), .pix_o(pix), .threshold_flag_o(flag), .gain_overflow_o(ovf),
    .delayed_sync_o(dsync), .line_pixel_port_i(port_in), .line_pixel_port_o(d_port),
    .line_pixel_port_oe_o(oe), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata));
  // ==========================================
  // bus and stream tasks
  task automatic wreg(input logic [6:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [6:0] a, output logic [15:0] d);
    @(posedge clk_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rreg
  task automatic periods(input int n);
    repeat (2 * n) @(posedge clk_i);
    #1;
  endtask : periods
  task automatic line(input logic s, input int n);
    @(posedge clk_i);
    sync_req <= s;
    periods(n);
  endtask : line
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test
  // ==========================================
  // scenarios
  task automatic t_regs;
    logic [15:0] d;
    `CHK("port_oe", 1'b0, oe)
    rreg(A_CTRL, d);
    `CHK("ctrl_reset", 16'h0000, d)
    wreg(7'h10, 16'hffff);
    rreg(7'h10, d);
    `CHK("unmapped", 16'h0000, d)
    wreg(A_CTRL, 16'h0100);
    #1;
    `CHK("port_oe", 1'b1, oe)
    wreg(A_CTRL, 16'h0000);
    $display("test regs done");
  endtask : t_regs
  task automatic t_gain;
    logic [15:0] d;
    logic [55:0] r;
    @(posedge clk_i);
    pix_req <= 16'h00ff;
    field   <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      r = GT[i];
      wreg(A_CTRL, {5'h00, 2'h3, 3'h0, r[41:40], 4'h0});
      wreg(A_GAIN, {12'h000, r[47:44]});
      wreg(A_THRESH, r[39:24]);
      for (int c = 0; c < 8; c++) begin
        wreg(A_COEF + 7'(c), {{8{r[55]}}, r[55:48]});
      end
      periods(24);
      `CHK("pix_out", r[23:8], pix)
      `CHK("gain_ovf", r[4], ovf)
      `CHK("thr_flag", r[0], flag)
      rreg(A_STATUS, d);
      `CHK("status_ovf", r[4], d[S_OVF])
      `CHK("status_thr", r[0], d[S_THR])
    end
    $display("test gain done");
  endtask : t_gain
  task automatic t_addr;
    logic [15:0] d;
    logic [9:0]  prev;
    logic        ok, wrapped;
    wreg(A_CTRL, 16'h0000);
    line(1'b1, 10);
    rreg(A_STATUS, d);
    `CHK("addr_sync", 10'h000, d[9:0])
    line(1'b0, 100);
    rreg(A_STATUS, d);
    `CHK("addr_run", 1'b1, d[9:0] >= 10'd98 && d[9:0] <= 10'd103)
    periods(1000);
    rreg(A_STATUS, d);
    `CHK("addr_max", AMAX_FULL, d[9:0])
    `CHK("stopped", 1'b1, d[S_STOP])
    wreg(A_CTRL, 16'h0008);
    line(1'b1, 4);
    line(1'b0, 600);
    rreg(A_STATUS, d);
    `CHK("addr_half", AMAX_HALF, d[9:0])
    wreg(A_CTRL, 16'h0004);
    line(1'b1, 4);
    line(1'b0, 1100);
    rreg(A_STATUS, d);
    `CHK("addr_quad", AMAX_HALF, d[9:0])
    wreg(A_LEN_LO, 16'h0001);
    wreg(A_LEN_HI, 16'h0002);
    pix_req <= 16'h005a;
    wreg(A_CTRL, 16'h0081);
    line(1'b1, 4);
    line(1'b0, 600);
    rreg(A_STATUS, d);
    `CHK("addr_prog", 10'h201, d[9:0])
    `CHK("port_out", 8'h5a, d_port)
    wreg(A_LEN_HI, 16'h0000);
    wreg(A_LEN_LO, 16'h0005);
    for (int m = 2; m < 4; m++) begin
      wreg(A_CTRL, 16'(m));
      line(1'b1, 4);
      line(1'b0, 2);
      ok = 1'b1;
      wrapped = 1'b0;
      prev = 10'h000;
      for (int k = 0; k < 14; k++) begin
        rreg(A_STATUS, d);
        ok = ok && (d[9:0] <= 10'd5);
        wrapped = wrapped || (d[9:0] < prev);
        prev = d[9:0];
      end
      `CHK("addr_wrap", 1'b1, ok && wrapped)
    end
    $display("test addr done");
  endtask : t_addr
  task automatic t_dsync;
    int n;
    wreg(A_CTRL, 16'h0000);
    wreg(A_SDELAY, 16'h0003);
    line(1'b0, 40);
    `CHK("dsync_low", 1'b0, dsync)
    @(posedge clk_i);
    sync_req <= 1'b1;
    n = 0;
    while (dsync !== 1'b1 && n < 100) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    `CHK("dsync_delay", 1'b1, n >= 6 && n <= 11)
    $display("test dsync done");
  endtask : t_dsync
  // ==========================================
  // timeout and main sequence
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      end_of_test();
    end
  end
  initial begin
    clk_i = 1'b0;
    nrst_i = 1'b0;
    addr = 7'h00;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    sync_req = 1'b0;
    field = 1'b0;
    pix_req = 16'h0000;
    repeat (5) @(posedge clk_i);
    nrst_i <= 1'b1;
    #1;
    t_regs();
    t_gain();
    t_addr();
    t_dsync();
    end_of_test();
  end
endmodule : cld_top_tb
